// file: jdm_mask.sv
// Jack detect interrupt masking with AXI4-Lite register access.
// Assumes event inputs come from detection logic on the same clock.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "jdm_map.svh"

module jdm_mask
    import jdm_pkg::*;
#(
    parameter int ADDR_W = 16    // Byte address width of the bus
) (
    input wire logic CORE_CLK_I,              // Core clock, 100 MHz
    input wire logic ARST_N_I,                // Async reset, active low
    input wire logic [15:0] EVT_I,            // Event pulses, status layout
    input wire logic [15:0] RAW_I,            // Raw event levels
    input wire logic [ADDR_W-1:0] AWADDR_I,   // Write address
    input wire logic AWVALID_I,               // Write address valid
    output logic AWREADY_O,                   // Write address ready
    input wire logic [31:0] WDATA_I,          // Write data
    input wire logic [3:0] WSTRB_I,           // Write byte strobes
    input wire logic WVALID_I,                // Write data valid
    output logic WREADY_O,                    // Write data ready
    output logic [1:0] BRESP_O,               // Write response
    output logic BVALID_O,                    // Write response valid
    input wire logic BREADY_I,                // Write response ready
    input wire logic [ADDR_W-1:0] ARADDR_I,   // Read address
    input wire logic ARVALID_I,               // Read address valid
    output logic ARREADY_O,                   // Read address ready
    output logic [31:0] RDATA_O,              // Read data
    output logic [1:0] RRESP_O,               // Read response
    output logic RVALID_O,                    // Read data valid
    input wire logic RREADY_I,                // Read data ready
    output logic IRQ_O                        // Interrupt, active high
);

    // Refuse an address bus too narrow for the map
    if (ADDR_W < 16) begin : g_addr_check
        $error("ADDR_W must be at least 16");
    end

    jdm_state_t q;        // Registered state
    jdm_state_t next_q;   // Next state
    logic [15:0] eff_mask;  // Masks as applied to the status bits
    logic [15:0] stat_view; // Status as software reads it

    // Word index of a byte address
    function automatic logic [13:0] word_of(input logic [15:0] addr);
        word_of = addr[15:2];
    endfunction

    // Whether a word index is mapped
    function automatic logic mapped(input logic [13:0] idx);
        mapped = (idx == `JDM_MASK_FIRST_IDX) ||
                 (idx == `JDM_MASK_SECOND_IDX) ||
                 (idx == `JDM_STATUS_IDX) ||
                 (idx == `JDM_CTRL_IDX);
    endfunction

    // Effective masks; press mask held while latched
    always_comb begin
        eff_mask = {q.mask_second, q.mask_first};
        if (q.ctrl[`JDM_CTRL_LATCH]) begin
            eff_mask[8] = q.press_held;
        end
    end

    // Readable status, raw or sticky for the selected sources
    always_comb begin
        stat_view = q.stat;
        if (!q.ctrl[`JDM_CTRL_SEL]) begin
            // Raw levels replace sticky bits
            stat_view = (q.stat & ~`JDM_STAT_SELECTED) |
                        (q.raw & `JDM_STAT_SELECTED);
        end
    end

    // Next state of registers and bus channels
    always_comb begin
        logic [13:0] widx;    // Word index of the pending write
        logic [13:0] ridx;    // Word index of the read
        logic do_write;       // Write carried out this cycle
        logic do_read;        // Read address taken this cycle
        logic [15:0] clr;     // Status bits cleared by software
        logic [15:0] set;     // Status bits set by events
        logic rel_evt;        // Release event this cycle
        logic shadow_pop;     // Shadow moved into visible bit
        widx = '0;
        ridx = '0;
        do_write = 1'b0;
        do_read = 1'b0;
        clr = '0;
        set = '0;
        rel_evt = 1'b0;
        shadow_pop = 1'b0;
        next_q = q;

        // Raw event levels, registered for reading
        next_q.raw = RAW_I & `JDM_STAT_VALID;

        // Capture write address and data in either order
        if (AWVALID_I && q.aw_rdy) begin
            next_q.aw_full = 1'b1;
            next_q.aw_addr = AWADDR_I[15:0];
        end
        if (WVALID_I && q.w_rdy) begin
            next_q.w_full = 1'b1;
            next_q.w_data = WDATA_I;
            next_q.w_strb = WSTRB_I;
        end

        // Carry out a write once both halves are held
        if (q.aw_full && q.w_full && !q.b_valid) begin
            do_write = 1'b1;
            widx = word_of(q.aw_addr);
            next_q.aw_full = 1'b0;
            next_q.w_full = 1'b0;
            next_q.b_valid = 1'b1;
            next_q.b_resp = mapped(widx) ? `JDM_RESP_OKAY
                                         : `JDM_RESP_SLVERR;
        end else if (q.b_valid && BREADY_I) begin
            next_q.b_valid = 1'b0;
        end

        // Register writes, byte lane zero for byte-wide registers
        if (do_write && q.w_strb[0]) begin
            if (widx == `JDM_MASK_FIRST_IDX) begin
                // Reserved bits stay zero
                next_q.mask_first = q.w_data[7:0] & `JDM_MASK_FIRST_RW;
            end else if (widx == `JDM_MASK_SECOND_IDX) begin
                // Reserved bits stay one
                next_q.mask_second = (q.w_data[7:0] &
                    `JDM_MASK_SECOND_RW) | `JDM_MASK_SECOND_RSV;
            end else if (widx == `JDM_CTRL_IDX) begin
                next_q.ctrl = q.w_data[2:0];
            end
        end
        // Write one to clear status, per byte lane
        if (do_write && widx == `JDM_STATUS_IDX) begin
            clr[7:0] = q.w_strb[0] ? q.w_data[7:0] : 8'h00;
            clr[15:8] = q.w_strb[1] ? q.w_data[15:8] : 8'h00;
        end

        // Read address taken when no answer is pending
        if (ARVALID_I && q.ar_rdy) begin
            do_read = 1'b1;
            ridx = word_of(ARADDR_I[15:0]);
            next_q.r_valid = 1'b1;
            next_q.r_resp = mapped(ridx) ? `JDM_RESP_OKAY
                                         : `JDM_RESP_SLVERR;
            if (ridx == `JDM_MASK_FIRST_IDX) begin
                next_q.r_data = {24'h000000, q.mask_first};
            end else if (ridx == `JDM_MASK_SECOND_IDX) begin
                next_q.r_data = {24'h000000, q.mask_second};
            end else if (ridx == `JDM_STATUS_IDX) begin
                next_q.r_data = {16'h0000, stat_view};
            end else if (ridx == `JDM_CTRL_IDX) begin
                next_q.r_data = {29'h00000000, q.ctrl};
            end else begin
                next_q.r_data = 32'h00000000;
            end
        end else if (q.r_valid && RREADY_I) begin
            next_q.r_valid = 1'b0;
        end

        // Event capture; release goes to shadow when bit is busy
        set = EVT_I & `JDM_STAT_VALID;
        rel_evt = set[`JDM_BIT_RELEASE];
        shadow_pop = do_read && (ridx == `JDM_STATUS_IDX) &&
                     (q.shadow != 2'h0) && !q.ctrl[`JDM_CTRL_WAKE];
        next_q.stat = (q.stat & ~clr) | set; // Set wins over clear
        if (q.ctrl[`JDM_CTRL_WAKE]) begin
            next_q.shadow = 2'h0;
        end else if (shadow_pop) begin
            // Shadow moves into the visible bit
            next_q.stat[`JDM_BIT_RELEASE] = 1'b1;
            if (rel_evt) begin
                next_q.shadow = q.shadow; // One in, one out
            end else begin
                next_q.shadow = q.shadow - 2'h1;
            end
        end else if (rel_evt && q.stat[`JDM_BIT_RELEASE] &&
                     !clr[`JDM_BIT_RELEASE]) begin
            // Visible bit busy: keep event in shadow
            if (q.shadow != `JDM_SHADOW_MAX) begin
                next_q.shadow = q.shadow + 2'h1;
            end
        end

        // Press mask follows live value until latched
        if (!q.ctrl[`JDM_CTRL_LATCH]) begin
            next_q.press_held = q.mask_second[0];
        end

        // Interrupt from unmasked sticky bits
        next_q.irq = |(q.stat & ~eff_mask & `JDM_STAT_VALID);

        // Ready flags from the next occupancy
        next_q.aw_rdy = !next_q.aw_full && !next_q.b_valid;
        next_q.w_rdy = !next_q.w_full && !next_q.b_valid;
        next_q.ar_rdy = !next_q.r_valid;
    end

    // State register
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            q <= '0;
            q.mask_first <= `JDM_MASK_FIRST_RST;
            q.mask_second <= `JDM_MASK_SECOND_RST;
            q.ctrl <= `JDM_CTRL_RST;
            q.press_held <= 1'b1;
            q.aw_rdy <= 1'b1;
            q.w_rdy <= 1'b1;
            q.ar_rdy <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops
    assign AWREADY_O = q.aw_rdy;
    assign WREADY_O = q.w_rdy;
    assign BVALID_O = q.b_valid;
    assign BRESP_O = q.b_resp;
    assign ARREADY_O = q.ar_rdy;
    assign RVALID_O = q.r_valid;
    assign RDATA_O = q.r_data;
    assign RRESP_O = q.r_resp;
    assign IRQ_O = q.irq;

    // Checks on the block's own behaviour
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    // Helper: a status read is taken
    logic stat_rd;
    assign stat_rd = ARVALID_I && q.ar_rdy &&
                     word_of(ARADDR_I[15:0]) == `JDM_STATUS_IDX;

    chk_irq_follows_unmasked: assert property (
        (|(q.stat & ~eff_mask & `JDM_STAT_VALID)) |=> IRQ_O)
        else $error("Interrupt low with an unmasked status bit");

    chk_irq_masked_low: assert property (
        !(|(q.stat & ~eff_mask & `JDM_STAT_VALID)) |=> !IRQ_O)
        else $error("Interrupt high with all sources masked");

    chk_first_mask_rsv: assert property (
        q.mask_first[4:0] == 5'h00)
        else $error("Reserved bits of first mask not zero");

    chk_second_mask_write: assert property (
        q.aw_full && q.w_full && !q.b_valid && q.w_strb[0] &&
        word_of(q.aw_addr) == `JDM_MASK_SECOND_IDX
        |=> q.mask_second == (($past(q.w_data[7:0]) &
            `JDM_MASK_SECOND_RW) | `JDM_MASK_SECOND_RSV) && BVALID_O)
        else $error("Second mask write not stored");

    chk_shadow_depth: assert property (
        q.shadow <= `JDM_SHADOW_MAX)
        else $error("Shadow holds more than two events");

    chk_shadow_move: assert property (
        stat_rd && q.shadow != 2'h0 && !q.ctrl[`JDM_CTRL_WAKE] &&
        !EVT_I[`JDM_BIT_RELEASE]
        |=> q.stat[`JDM_BIT_RELEASE] && q.shadow == $past(q.shadow) - 2'h1)
        else $error("Status read did not move shadow");

    chk_shadow_wake: assert property (
        q.ctrl[`JDM_CTRL_WAKE] |=> q.shadow == 2'h0)
        else $error("Shadow active in wake mode");

    chk_press_latch: assert property (
        q.ctrl[`JDM_CTRL_LATCH] ##1 q.ctrl[`JDM_CTRL_LATCH]
        |-> $stable(q.press_held))
        else $error("Latched press mask changed");

    chk_raw_select: assert property (
        stat_rd && !q.ctrl[`JDM_CTRL_SEL]
        |=> RVALID_O && RDATA_O[6:5] == $past(q.raw[6:5]))
        else $error("Raw status not shown when selected");

    chk_bresp_hold: assert property (
        BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("Write response dropped before taken");

endmodule

// file: jdm_map.svh
// Register map, field positions and reset values of the jack detect masks.
// Assumes a 32-bit AXI4-Lite slave, one aligned word per register.
// Notes on behaviour
// - Mask bit 0 passes source, 1 blocks.
// - First byte: sense, plug, unplug masks.
// - Second byte: detect edges, float, release, press.
// - Release source keeps up to two shadowed events.
// - Each status read moves shadow into bit.
// - No shadow capture while in wake mode.
// - Press mask follows the standby domain latch.
// - Selection shows raw or sticky processed status.
`ifndef JDM_MAP_SVH
`define JDM_MAP_SVH

// Register indices; byte address is four times the index
`define JDM_MASK_FIRST_IDX 14'h1b79
`define JDM_MASK_SECOND_IDX 14'h1b7a
`define JDM_STATUS_IDX 14'h1b7b
`define JDM_CTRL_IDX 14'h1b7c

// Reset values
`define JDM_MASK_FIRST_RST 8'he0
`define JDM_MASK_SECOND_RST 8'hff
`define JDM_CTRL_RST 3'h0

// Writable and reserved bits of the two mask bytes
`define JDM_MASK_FIRST_RW 8'he0
`define JDM_MASK_SECOND_RW 8'hc7
`define JDM_MASK_SECOND_RSV 8'h38

// Status bits, laid out as {second mask byte, first mask byte}
`define JDM_STAT_VALID 16'hc7e0
`define JDM_BIT_RELEASE 9
`define JDM_STAT_SELECTED 16'h0360

// Control register fields
`define JDM_CTRL_SEL 0
`define JDM_CTRL_LATCH 1
`define JDM_CTRL_WAKE 2

// Shadow depth and bus answers
`define JDM_SHADOW_MAX 2'h2
`define JDM_RESP_OKAY 2'h0
`define JDM_RESP_SLVERR 2'h2

`endif

// file: jdm_pkg.sv
// Types shared by the jack detect mask block.
// Assumes the constants of jdm_map.svh for widths of fields.
package jdm_pkg;

    // Whole register state of the block
    typedef struct packed {
        logic [7:0] mask_first;   // Sense, plug, unplug masks
        logic [7:0] mask_second;  // Edge, float, release, press masks
        logic [2:0] ctrl;         // Selection, latch, wake
        logic [15:0] stat;        // Sticky event bits
        logic [15:0] raw;         // Raw event levels, registered
        logic [1:0] shadow;       // Pending release events
        logic press_held;         // Press mask held by the latch
        logic irq;                // Interrupt output
        logic aw_full;            // Write address captured
        logic [15:0] aw_addr;     // Captured write address
        logic w_full;             // Write data captured
        logic [31:0] w_data;      // Captured write data
        logic [3:0] w_strb;       // Captured byte strobes
        logic aw_rdy;             // Write address ready
        logic w_rdy;              // Write data ready
        logic b_valid;            // Write response valid
        logic [1:0] b_resp;       // Write response code
        logic ar_rdy;             // Read address ready
        logic r_valid;            // Read data valid
        logic [31:0] r_data;      // Read data
        logic [1:0] r_resp;       // Read response code
    } jdm_state_t;

endpackage

// file: tb_jack_detect_irq_masking.sv
// Self-checking bench for the jack detect interrupt mask block.
// Assumes jdm_map.svh and jdm_pkg are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`include "jdm_map.svh"

// Compare two values, count the check, report a mismatch
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
end

module tb_jack_detect_irq_masking
    import jdm_pkg::*;
;
    localparam logic [15:0] A_M1 = {`JDM_MASK_FIRST_IDX, 2'b00};
    localparam logic [15:0] A_M2 = {`JDM_MASK_SECOND_IDX, 2'b00};
    localparam logic [15:0] A_ST = {`JDM_STATUS_IDX, 2'b00};
    localparam logic [15:0] A_CT = {`JDM_CTRL_IDX, 2'b00};
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [15:0] evt, raw, awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] m1, m2;     // Model of the two mask bytes
    logic pm, latch, wake;  // Applied press mask, latch and wake
    logic [15:0] sticky, e, v;  // Model status, expected, scratch
    int shq[$];             // Model shadow of release events
    int n_errors, tests_run, cyc;
    int srcs[8] = '{7, 6, 5, 15, 14, 10, 9, 8};

    jdm_mask i_dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .EVT_I(evt),
        .RAW_I(raw), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
        .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .IRQ_O(irq));

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, ends the run
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Hang guard on the whole run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    // Bus write; holds each channel until taken, waits for response
    task automatic wr(input logic [15:0] a, input logic [31:0] x,
                      output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a; wdata <= x; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        // Wait for the answer; only the bench timeout ends a hang
        forever begin
            @(posedge clk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    // Bus read; data and response taken at the handshake edge
    task automatic rd(input logic [15:0] a, output logic [31:0] x,
                      output logic [1:0] rs);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        // Wait for the answer; only the bench timeout ends a hang
        forever begin
            @(posedge clk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid) begin
                x = rdata; rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // Mask and control writes, mirrored in the model
    task automatic wm(input logic [15:0] x);
        wr(A_M1, {24'h0, x[7:0]}, r);
        wr(A_M2, {24'h0, x[15:8]}, r);
        `CHK("mask bresp", `JDM_RESP_OKAY, r)
        m1 = x[7:0] & `JDM_MASK_FIRST_RW;
        m2 = (x[15:8] & `JDM_MASK_SECOND_RW) | `JDM_MASK_SECOND_RSV;
        if (!latch) pm = m2[0];
    endtask
    task automatic wc(input logic [2:0] x);
        wr(A_CT, {29'h0, x}, r);
        if (!x[1] || !latch) pm = m2[0];
        latch = x[1]; wake = x[2];
        if (wake) shq.delete();
    endtask

    // One event pulse; release events beyond the visible bit shadowed
    task automatic pulse(input int b);
        @(posedge clk);
        evt <= 16'h1 << b;
        @(posedge clk);
        evt <= 16'h0;
        if (b == 9 && sticky[9]) begin
            if (!wake && shq.size() < 2) shq.push_back(1);
        end else sticky[b] = 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // Write-one-to-clear of one status bit
    task automatic clr(input int b);
        wr(A_ST, 32'h1 << b, r);
        sticky[b] = 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Status read in sticky view; a pending shadow event moves in
    task automatic rds();
        e = sticky & `JDM_STAT_VALID;
        rd(A_ST, d, r);
        if (shq.size() > 0) begin
            sticky[9] = 1'b1;
            void'(shq.pop_front());
        end
    endtask

    function automatic logic eirq();
        return |(sticky & `JDM_STAT_VALID & ~{m2[7:1], pm, m1});
    endfunction

    // Main sequence
    initial begin
        {evt, raw, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf; rst_n = 1'b0;
        m1 = 8'he0; m2 = 8'hff; pm = 1'b1; latch = 0; wake = 0;
        sticky = '0;
        void'($urandom(32'h77aa6a64));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_M1, d, r);
        `CHK("mask_first", 8'he0, d[7:0])
        rd(A_M2, d, r);
        `CHK("mask_second", 8'hff, d[7:0])
        rd(16'h0100, d, r);
        `CHK("unmapped rresp", `JDM_RESP_SLVERR, r)
        `CHK("unmapped rdata", 32'h0, d)
        wr(16'h0104, 32'hff, r);
        `CHK("unmapped bresp", `JDM_RESP_SLVERR, r)
        // Random mask contents read back through reserved bits
        for (int i = 0; i < 4; i++) begin
            wm(16'($urandom));
            rd(A_M1, d, r);
            `CHK("mask_first", m1, d[7:0])
            rd(A_M2, d, r);
            `CHK("mask_second", m2, d[7:0])
        end
        wc(3'h1);
        // Every source, once unmasked and once masked
        foreach (srcs[i]) begin
            for (int k = 0; k < 2; k++) begin
                v = k ? 16'hffff : ~(16'h1 << srcs[i]);
                wm(v);
                pulse(srcs[i]);
                `CHK("irq", eirq(), irq)
                rds();
                `CHK("status", e, d[15:0])
                clr(srcs[i]);
                `CHK("irq", 1'b0, irq)
            end
        end
        // Release shadow two deep, third surplus event lost
        for (int i = 0; i < 4; i++) pulse(9);
        for (int i = 0; i < 3; i++) begin
            clr(9);
            rds();
            `CHK("shadow", e, d[15:0])
            rds();
            `CHK("shadow", e, d[15:0])
        end
        clr(9);
        // Wake mode keeps no shadow
        wc(3'h5);
        for (int i = 0; i < 3; i++) pulse(9);
        clr(9);
        rds();
        rds();
        `CHK("wake shadow", e, d[15:0])
        wc(3'h1);
        // Press mask frozen while the standby latch is set
        wm(16'hfeff);
        wc(3'h3);
        wm(16'hffff);
        rd(A_M2, d, r);
        `CHK("mask_second", 8'hff, d[7:0])
        pulse(8);
        `CHK("irq latched", eirq(), irq)
        clr(8);
        wc(3'h1);
        pulse(8);
        `CHK("irq unlatched", eirq(), irq)
        clr(8);
        // Raw versus sticky status view
        wc(3'h0);
        raw <= 16'($urandom);
        repeat (3) @(posedge clk);
        rd(A_ST, d, r);
        `CHK("raw view", raw & `JDM_STAT_SELECTED, d[15:0])
        wc(3'h1);
        rds();
        `CHK("sticky view", e, d[15:0])
        final_report();
    end
endmodule
